// ---- design/ppcb_defs.vh ----
// Constants for the port pin configuration bank
// Function
// R1: A skip bit of 1 makes the crossbar decoder pass over that pin of ports 1 to 3; 0 leaves it free.
// R2: Software should skip pins used as analog inputs or special functions such as start input.
// R3: Latch 0 drives the pin low; latch 1 drives high in push-pull or floats in open-drain.
// R4: Port 2 latch values reach the pins per crossbar routing and only while the crossbar is on.
// R5: Port 3 and port 4 latch values reach their pins as written, with no routing.
// R6: A port data read returns 0 for every bit whose pin is an analog input.
// R7: A port data read returns the sampled pin level for digital inputs, not the latch.
// R8: An analog pin has its pull-up, output driver and input receiver all disabled.
// R9: Input mode bit 0 means analog and 1 digital; input mode registers reset to all ones.
// R10: Output mode bit 0 means open-drain and 1 push-pull; mode and skip registers reset to zero.
// R11: The output mode bit has no effect while the pin is an analog input.
// R12: Port 3 pins 1 to 7 are unimplemented unless the large package is selected.
// R13: Port 4 and its registers exist only in the large package.
// R14: While the crossbar enable is 0 all port output drivers are off.
// R15: Read-modify-write reads of a port register return the latch, not the pin.
// R16: Pull-ups are on for digital pins not in push-pull unless the pull-up disable bit is 1.
// R17: The block exports a per-pin skip vector to the crossbar decoder.
`ifndef PPCB_DEFS_VH
`define PPCB_DEFS_VH
`define PPCB_AW 8
`define PPCB_DW 8
`define PPCB_A_P2_LATCH 8'hA0
`define PPCB_A_P2_DRIVE 8'hA6
`define PPCB_A_P3_DRIVE 8'hA7
`define PPCB_A_P4_DRIVE 8'hAE
`define PPCB_A_P3_LATCH 8'hB0
`define PPCB_A_P4_LATCH 8'hC7
`define PPCB_A_P1_BYPASS 8'hD5
`define PPCB_A_P2_BYPASS 8'hD6
`define PPCB_A_P3_BYPASS 8'hDF
`define PPCB_A_P2_ANALOG 8'hF3
`define PPCB_A_P3_ANALOG 8'hF4
`define PPCB_A_P4_ANALOG 8'hF5
`define PPCB_RST_LATCH 8'hFF
`define PPCB_RST_ANALOG 8'hFF
`define PPCB_RST_DRIVE 8'h00
`define PPCB_RST_BYPASS 8'h00
`define PPCB_ALL_PINS 8'hFF
`define PPCB_NO_PINS 8'h00
`define PPCB_P3_SMALL_PINS 8'h01
`define PPCB_NREG 12
`define PPCB_SEL_NONE 12'h000
`endif

// ---- design/ppcb_pin_cell.v ----
// One 8-pin port: input sync, drive, pull-up and read value
`timescale 1ns/10ps
`include "ppcb_defs.vh"
module ppcb_pin_cell #(
  parameter [7:0] IMPL = 8'hFF
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Configuration
  input wire [7:0] latch,
  input wire [7:0] analog_n,
  input wire [7:0] push_pull,
  input wire [7:0] route_sel,
  input wire [7:0] route_data,
  input wire xbar_en,
  input wire pull_dis,
  // Pins
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  output reg [7:0] pull_en,
  // Read value of the pins
  output wire [7:0] pin_level
);
  reg [7:0] meta_reg;
  reg [7:0] sync_reg;
  wire [7:0] dig;
  wire [7:0] value;
  assign dig = analog_n & IMPL;
  assign value = (route_sel & route_data) | (~route_sel & latch); // see R4 see R5
  // Receiver off on analog pins, so they read low
  assign pin_level = sync_reg & dig; // see R6 see R7 see R8
  always @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= `PPCB_NO_PINS;
      sync_reg <= `PPCB_NO_PINS;
      pin_out <= `PPCB_NO_PINS;
      pin_oe <= `PPCB_NO_PINS;
      pull_en <= `PPCB_NO_PINS;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      pin_out <= value & dig; // see R3
      // Open-drain high releases the pin; analog ignores drive mode
      pin_oe <= {8{xbar_en}} & dig & (~value | push_pull); // see R3 see R11 see R14
      pull_en <= {8{~pull_dis}} & dig & ~push_pull; // see R16 see R8
    end
  end
endmodule // ppcb_pin_cell

// ---- design/ppcb_port_bank.v ----
// Port 1-4 configuration registers, skip vector and pin logic
`timescale 1ns/10ps
`include "ppcb_defs.vh"
module ppcb_port_bank #(
  parameter PKG48 = 1
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Special function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  input wire sfr_rmw,
  output reg [7:0] sfr_rdata,
  output reg sfr_rvalid,
  // Global controls
  input wire global_crossbar_enable,
  input wire global_pullup_disable,
  // Crossbar routing for port 2
  input wire [7:0] xbar_p2_sel,
  input wire [7:0] xbar_p2_data,
  // Skip vector to the crossbar decoder, ports 3..1
  output reg [23:0] skip_vec,
  // Port 2 pins
  input wire [7:0] port2_pin_in,
  output wire [7:0] port2_pin_out,
  output wire [7:0] port2_pin_oe,
  output wire [7:0] port2_pull_en,
  // Port 3 pins
  input wire [7:0] port3_pin_in,
  output wire [7:0] port3_pin_out,
  output wire [7:0] port3_pin_oe,
  output wire [7:0] port3_pull_en,
  // Port 4 pins
  input wire [7:0] port4_pin_in,
  output wire [7:0] port4_pin_out,
  output wire [7:0] port4_pin_oe,
  output wire [7:0] port4_pull_en
);
  // Unimplemented pins keep their reset value and read as zero
  localparam [7:0] P3_IMPL = PKG48 ? `PPCB_ALL_PINS : `PPCB_P3_SMALL_PINS; // see R12
  localparam [7:0] P4_IMPL = PKG48 ? `PPCB_ALL_PINS : `PPCB_NO_PINS; // see R13
  localparam [23:0] IMPL_ALL = {P4_IMPL, P3_IMPL, `PPCB_ALL_PINS};

  // Register select indices
  localparam S_P2_LATCH = 0;
  localparam S_P3_LATCH = 1;
  localparam S_P4_LATCH = 2;
  localparam S_P2_ANALOG = 3;
  localparam S_P3_ANALOG = 4;
  localparam S_P4_ANALOG = 5;
  localparam S_P2_DRIVE = 6;
  localparam S_P3_DRIVE = 7;
  localparam S_P4_DRIVE = 8;
  localparam S_P1_BYPASS = 9;
  localparam S_P2_BYPASS = 10;
  localparam S_P3_BYPASS = 11;

  // Configuration storage
  reg [7:0] port2_output_latch_reg;
  reg [7:0] port3_output_latch_reg;
  reg [7:0] port4_output_latch_reg;
  reg [7:0] port2_analog_select_reg;
  reg [7:0] port3_analog_select_reg;
  reg [7:0] port4_analog_select_reg;
  reg [7:0] port2_output_drive_mode_reg;
  reg [7:0] port3_output_drive_mode_reg;
  reg [7:0] port4_output_drive_mode_reg;
  reg [7:0] port1_crossbar_bypass_reg;
  reg [7:0] port2_crossbar_bypass_reg;
  reg [7:0] port3_crossbar_bypass_reg;
  reg [7:0] rdata_next;
  wire [11:0] sel;
  wire [23:0] pin_level;
  wire [23:0] pin_out_all;
  wire [23:0] pin_oe_all;
  wire [23:0] pull_en_all;

  // Address decode shared by the write and the read path
  function [11:0] reg_sel;
    input [7:0] addr;
    input p4_present;
    begin
      reg_sel = `PPCB_SEL_NONE;
      if (addr == `PPCB_A_P2_LATCH) begin
        reg_sel[S_P2_LATCH] = 1'b1;
      end else if (addr == `PPCB_A_P3_LATCH) begin
        reg_sel[S_P3_LATCH] = 1'b1;
      end else if (addr == `PPCB_A_P4_LATCH) begin
        reg_sel[S_P4_LATCH] = p4_present; // see R13
      end else if (addr == `PPCB_A_P2_ANALOG) begin
        reg_sel[S_P2_ANALOG] = 1'b1;
      end else if (addr == `PPCB_A_P3_ANALOG) begin
        reg_sel[S_P3_ANALOG] = 1'b1;
      end else if (addr == `PPCB_A_P4_ANALOG) begin
        reg_sel[S_P4_ANALOG] = p4_present; // see R13
      end else if (addr == `PPCB_A_P2_DRIVE) begin
        reg_sel[S_P2_DRIVE] = 1'b1;
      end else if (addr == `PPCB_A_P3_DRIVE) begin
        reg_sel[S_P3_DRIVE] = 1'b1;
      end else if (addr == `PPCB_A_P4_DRIVE) begin
        reg_sel[S_P4_DRIVE] = p4_present; // see R13
      end else if (addr == `PPCB_A_P1_BYPASS) begin
        reg_sel[S_P1_BYPASS] = 1'b1;
      end else if (addr == `PPCB_A_P2_BYPASS) begin
        reg_sel[S_P2_BYPASS] = 1'b1;
      end else if (addr == `PPCB_A_P3_BYPASS) begin
        reg_sel[S_P3_BYPASS] = 1'b1;
      end
    end
  endfunction

  assign sel = reg_sel(sfr_addr, PKG48 != 0);

  // Latches: unimplemented bits hold their reset value
  always @(posedge clock) begin
    if (!rst_n) begin
      port2_output_latch_reg <= `PPCB_RST_LATCH;
      port3_output_latch_reg <= `PPCB_RST_LATCH;
      port4_output_latch_reg <= `PPCB_RST_LATCH;
    end else if (sfr_wr) begin
      if (sel[S_P2_LATCH]) begin
        port2_output_latch_reg <= sfr_wdata;
      end
      if (sel[S_P3_LATCH]) begin
        port3_output_latch_reg <= (sfr_wdata & P3_IMPL) | (`PPCB_RST_LATCH & ~P3_IMPL); // see R12
      end
      if (sel[S_P4_LATCH]) begin
        port4_output_latch_reg <= sfr_wdata;
      end
    end
  end

  // Input mode: all digital after reset
  always @(posedge clock) begin
    if (!rst_n) begin
      port2_analog_select_reg <= `PPCB_RST_ANALOG; // see R9
      port3_analog_select_reg <= `PPCB_RST_ANALOG; // see R9
      port4_analog_select_reg <= `PPCB_RST_ANALOG; // see R9
    end else if (sfr_wr) begin
      if (sel[S_P2_ANALOG]) begin
        port2_analog_select_reg <= sfr_wdata;
      end
      if (sel[S_P3_ANALOG]) begin
        port3_analog_select_reg <= (sfr_wdata & P3_IMPL) | (`PPCB_RST_ANALOG & ~P3_IMPL); // see R12
      end
      if (sel[S_P4_ANALOG]) begin
        port4_analog_select_reg <= sfr_wdata;
      end
    end
  end

  // Output mode: open-drain after reset
  always @(posedge clock) begin
    if (!rst_n) begin
      port2_output_drive_mode_reg <= `PPCB_RST_DRIVE; // see R10
      port3_output_drive_mode_reg <= `PPCB_RST_DRIVE; // see R10
      port4_output_drive_mode_reg <= `PPCB_RST_DRIVE; // see R10
    end else if (sfr_wr) begin
      if (sel[S_P2_DRIVE]) begin
        port2_output_drive_mode_reg <= sfr_wdata;
      end
      if (sel[S_P3_DRIVE]) begin
        port3_output_drive_mode_reg <= sfr_wdata & P3_IMPL; // see R12
      end
      if (sel[S_P4_DRIVE]) begin
        port4_output_drive_mode_reg <= sfr_wdata;
      end
    end
  end

  // Skip masks, also the flops behind the exported skip vector
  always @(posedge clock) begin
    if (!rst_n) begin
      port1_crossbar_bypass_reg <= `PPCB_RST_BYPASS; // see R10
      port2_crossbar_bypass_reg <= `PPCB_RST_BYPASS; // see R10
      port3_crossbar_bypass_reg <= `PPCB_RST_BYPASS; // see R10
    end else if (sfr_wr) begin
      if (sel[S_P1_BYPASS]) begin
        port1_crossbar_bypass_reg <= sfr_wdata;
      end
      if (sel[S_P2_BYPASS]) begin
        port2_crossbar_bypass_reg <= sfr_wdata;
      end
      if (sel[S_P3_BYPASS]) begin
        port3_crossbar_bypass_reg <= sfr_wdata & P3_IMPL; // see R12
      end
    end
  end

  // Skip vector follows the masks one cycle later, as the decoder samples it
  always @(posedge clock) begin
    if (!rst_n) begin
      skip_vec <= {`PPCB_RST_BYPASS, `PPCB_RST_BYPASS, `PPCB_RST_BYPASS};
    end else begin
      skip_vec <= {port3_crossbar_bypass_reg, port2_crossbar_bypass_reg,
        port1_crossbar_bypass_reg}; // see R1 see R17
    end
  end

  // Read mux: port data reads the pins unless the core is doing read-modify-write
  always @* begin
    rdata_next = `PPCB_NO_PINS;
    if (sel[S_P2_LATCH]) begin
      rdata_next = sfr_rmw ? port2_output_latch_reg : pin_level[7:0]; // see R15 see R7
    end else if (sel[S_P3_LATCH]) begin
      rdata_next = (sfr_rmw ? port3_output_latch_reg : pin_level[15:8]) & P3_IMPL; // see R15
    end else if (sel[S_P4_LATCH]) begin
      rdata_next = sfr_rmw ? port4_output_latch_reg : pin_level[23:16]; // see R15
    end else if (sel[S_P2_ANALOG]) begin
      rdata_next = port2_analog_select_reg;
    end else if (sel[S_P3_ANALOG]) begin
      rdata_next = port3_analog_select_reg & P3_IMPL;
    end else if (sel[S_P4_ANALOG]) begin
      rdata_next = port4_analog_select_reg;
    end else if (sel[S_P2_DRIVE]) begin
      rdata_next = port2_output_drive_mode_reg;
    end else if (sel[S_P3_DRIVE]) begin
      rdata_next = port3_output_drive_mode_reg;
    end else if (sel[S_P4_DRIVE]) begin
      rdata_next = port4_output_drive_mode_reg;
    end else if (sel[S_P1_BYPASS]) begin
      rdata_next = port1_crossbar_bypass_reg;
    end else if (sel[S_P2_BYPASS]) begin
      rdata_next = port2_crossbar_bypass_reg;
    end else if (sel[S_P3_BYPASS]) begin
      rdata_next = port3_crossbar_bypass_reg;
    end
  end

  // Read data is held until the next read
  always @(posedge clock) begin
    if (!rst_n) begin
      sfr_rdata <= `PPCB_NO_PINS;
      sfr_rvalid <= 1'b0;
    end else begin
      sfr_rvalid <= sfr_rd;
      if (sfr_rd) begin
        sfr_rdata <= rdata_next;
      end
    end
  end

  // Per-port pin logic; only port 2 sees crossbar routing
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_port
      wire [7:0] lat;
      wire [7:0] ana;
      wire [7:0] drv;
      wire [7:0] rsel;
      wire [7:0] pin_in;
      if (gi == 0) begin : g_p2
        assign lat = port2_output_latch_reg;
        assign ana = port2_analog_select_reg;
        assign drv = port2_output_drive_mode_reg;
        assign rsel = xbar_p2_sel; // see R4
        assign pin_in = port2_pin_in;
      end else if (gi == 1) begin : g_p3
        assign lat = port3_output_latch_reg;
        assign ana = port3_analog_select_reg;
        assign drv = port3_output_drive_mode_reg;
        assign rsel = `PPCB_NO_PINS; // see R5
        assign pin_in = port3_pin_in;
      end else begin : g_p4
        assign lat = port4_output_latch_reg;
        assign ana = port4_analog_select_reg;
        assign drv = port4_output_drive_mode_reg;
        assign rsel = `PPCB_NO_PINS; // see R5
        assign pin_in = port4_pin_in;
      end
      ppcb_pin_cell #(
        .IMPL(IMPL_ALL[gi*8 +: 8])
      ) u_cell (
        .clock(clock),
        .rst_n(rst_n),
        .latch(lat),
        .analog_n(ana),
        .push_pull(drv),
        .route_sel(rsel),
        .route_data(xbar_p2_data),
        .xbar_en(global_crossbar_enable),
        .pull_dis(global_pullup_disable),
        .pin_in(pin_in),
        .pin_out(pin_out_all[gi*8 +: 8]),
        .pin_oe(pin_oe_all[gi*8 +: 8]),
        .pull_en(pull_en_all[gi*8 +: 8]),
        .pin_level(pin_level[gi*8 +: 8])
      );
    end
  endgenerate

  assign port2_pin_out = pin_out_all[7:0];
  assign port2_pin_oe = pin_oe_all[7:0];
  assign port2_pull_en = pull_en_all[7:0];
  assign port3_pin_out = pin_out_all[15:8];
  assign port3_pin_oe = pin_oe_all[15:8];
  assign port3_pull_en = pull_en_all[15:8];
  assign port4_pin_out = pin_out_all[23:16];
  assign port4_pin_oe = pin_oe_all[23:16];
  assign port4_pull_en = pull_en_all[23:16];
endmodule // ppcb_port_bank

// ---- sim/ppcb_port_bank_chk.sv ----
// Concurrent checks on the port bank register port and pins
`timescale 1ns/10ps
module ppcb_port_bank_chk #(
  parameter PKG48 = 1
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire sfr_rmw,
  input wire [7:0] sfr_rdata,
  input wire sfr_rvalid,
  // Global and routing
  input wire global_crossbar_enable,
  input wire global_pullup_disable,
  input wire [7:0] xbar_p2_sel,
  input wire [7:0] xbar_p2_data,
  input wire [23:0] skip_vec,
  // Pins
  input wire [7:0] port2_pin_out,
  input wire [7:0] port2_pin_oe,
  input wire [7:0] port2_pull_en,
  input wire [7:0] port3_pin_out,
  input wire [7:0] port3_pin_oe,
  input wire [7:0] port3_pull_en,
  input wire [7:0] port4_pin_out,
  input wire [7:0] port4_pin_oe,
  input wire [7:0] port4_pull_en
);
  wire [7:0] oe_all = port2_pin_oe | port3_pin_oe | port4_pin_oe;
  wire [7:0] pull_all = port2_pull_en | port3_pull_en | port4_pull_en;
  wire [7:0] hi_pull = (port2_pin_oe & port2_pin_out & port2_pull_en)
    | (port3_pin_oe & port3_pin_out & port3_pull_en) | (port4_pin_oe & port4_pin_out & port4_pull_en);
  wire p4_addr = sfr_addr inside {8'hAE, 8'hC7, 8'hF5};
  wire mapped = (sfr_addr inside {8'hA0, 8'hA6, 8'hA7, 8'hB0, 8'hD5, 8'hD6, 8'hDF, 8'hF3, 8'hF4})
    || (p4_addr && PKG48 != 0);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_xbar_off_quiet: assert property (!global_crossbar_enable |=> oe_all == 8'h00)
    else $error("driver on while crossbar off");
  a_drive_high_nopull: assert property (hi_pull == 8'h00)
    else $error("pull-up on a pin driven high");
  a_pud_all_off: assert property (global_pullup_disable |=> pull_all == 8'h00)
    else $error("pull-up on while disabled");
  // Reset clears the vector, so a change right after reset is not a write
  a_skip_cause: assert property ($changed(skip_vec) && $past(rst_n) |->
    $past(sfr_wr, 2) && ($past(sfr_addr, 2) inside {8'hD5, 8'hD6, 8'hDF}))
    else $error("skip vector changed without a bypass write");
  a_read_answer: assert property (sfr_rd |=> sfr_rvalid)
    else $error("read not answered");
  a_rdata_holds: assert property (!sfr_rvalid && $past(rst_n) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_routed_value: assert property ((port2_pin_oe & $past(xbar_p2_sel)
    & (port2_pin_out ^ $past(xbar_p2_data))) == 8'h00)
    else $error("routed pin not driving peripheral value");
  c_rmw_read: cover property (sfr_rd && sfr_rmw);
  c_p2_driving: cover property (global_crossbar_enable && port2_pin_oe != 8'h00);
  c_skip_set: cover property ($changed(skip_vec));
endmodule // ppcb_port_bank_chk

bind ppcb_port_bank ppcb_port_bank_chk #(.PKG48(PKG48)) u_chk (.*);

// ---- sim/ppcb_pin_model.sv ----
// Pin side model: outside drivers, weak pull-ups and floating lines
`timescale 1ns/10ps
module ppcb_pin_model (
  // Clock
  input wire clock,
  // Block side
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pull_en,
  // Outside drive
  input wire [7:0] ext_val,
  input wire [7:0] ext_en,
  // Level seen by the block
  output wire [7:0] pin_level
);
  reg [7:0] float_reg = 8'h55;
  // A line nobody holds wanders, so no check can lean on a settled value
  always @(posedge clock) begin
    float_reg <= ~float_reg;
  end
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pull_en | float_reg));
endmodule // ppcb_pin_model

// ---- sim/tb_ppcb_port_bank.sv ----
// Self-checking bench for the port pin configuration bank
`timescale 1ns/10ps
module tb_ppcb_port_bank;
  localparam [95:0] reg_addrs = 96'hA0A6A7AE_B0C7D5D6_DFF3F4F5;
  localparam [95:0] reg_resets = 96'hFF000000_FFFF0000_00FFFFFF;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg [7:0] sfr_wdata = 8'h00;
  reg sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
  reg global_crossbar_enable = 1'b0, global_pullup_disable = 1'b0;
  reg [7:0] xbar_p2_sel = 8'h00, xbar_p2_data = 8'h00;
  reg [23:0] ext_val = 24'h000000, ext_en = 24'h000000;
  wire [7:0] sfr_rdata;
  wire sfr_rvalid;
  wire [23:0] skip_vec;
  wire [7:0] port2_pin_in, port2_pin_out, port2_pin_oe, port2_pull_en;
  wire [7:0] port3_pin_in, port3_pin_out, port3_pin_oe, port3_pull_en;
  wire [7:0] port4_pin_in, port4_pin_out, port4_pin_oe, port4_pull_en;
  wire [7:0] small_rdata, small_p3_oe, small_p4_oe, small_p4_pull;
  integer errors = 0, check_count = 0;
  ppcb_port_bank dut (.*);
  // Small package copy on the same bus and pins
  ppcb_port_bank #(.PKG48(0)) dut_small (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
    .sfr_rdata(small_rdata), .sfr_rvalid(), .global_crossbar_enable(global_crossbar_enable),
    .global_pullup_disable(global_pullup_disable), .xbar_p2_sel(xbar_p2_sel),
    .xbar_p2_data(xbar_p2_data), .skip_vec(), .port2_pin_in(port2_pin_in), .port2_pin_out(),
    .port2_pin_oe(), .port2_pull_en(), .port3_pin_in(port3_pin_in), .port3_pin_out(),
    .port3_pin_oe(small_p3_oe), .port3_pull_en(), .port4_pin_in(port4_pin_in),
    .port4_pin_out(), .port4_pin_oe(small_p4_oe), .port4_pull_en(small_p4_pull));
  ppcb_pin_model m2 (.clock(clock), .pin_out(port2_pin_out), .pin_oe(port2_pin_oe),
    .pull_en(port2_pull_en), .ext_val(ext_val[7:0]), .ext_en(ext_en[7:0]), .pin_level(port2_pin_in));
  ppcb_pin_model m3 (.clock(clock), .pin_out(port3_pin_out), .pin_oe(port3_pin_oe),
    .pull_en(port3_pull_en), .ext_val(ext_val[15:8]), .ext_en(ext_en[15:8]), .pin_level(port3_pin_in));
  ppcb_pin_model m4 (.clock(clock), .pin_out(port4_pin_out), .pin_oe(port4_pin_oe),
    .pull_en(port4_pull_en), .ext_val(ext_val[23:16]), .ext_en(ext_en[23:16]), .pin_level(port4_pin_in));
  always #5 clock = ~clock;
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input string name, input [23:0] seen, input [23:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task settle(input integer n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clock);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    settle(1);
    sfr_wr = 1'b0;
  endtask
  task rd(input [7:0] a, input m, output [7:0] d);
    @(posedge clock);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    sfr_rmw = m;
    settle(1);
    sfr_rd = 1'b0;
    sfr_rmw = 1'b0;
    chk("rvalid", sfr_rvalid, 24'h1);
    d = sfr_rdata;
  endtask
  task t_regs;
    reg [7:0] d;
    integer i;
    for (i = 0; i < 12; i = i + 1) begin
      rd(reg_addrs[95 - 8 * i -: 8], 1'b1, d);
      chk("reset value", d, reg_resets[95 - 8 * i -: 8]);
      wr(reg_addrs[95 - 8 * i -: 8], 8'h5A);
      rd(reg_addrs[95 - 8 * i -: 8], 1'b1, d);
      chk("readback", d, 24'h5A);
      wr(reg_addrs[95 - 8 * i -: 8], reg_resets[95 - 8 * i -: 8]);
    end
    rd(8'hA1, 1'b0, d);
    chk("unmapped", d, 24'h0);
  endtask
  task t_skip;
    wr(8'hD5, 8'h81);
    wr(8'hD6, 8'h3C);
    wr(8'hDF, 8'h0F);
    settle(2);
    chk("skip_vec", skip_vec, 24'h0F3C81);
    wr(8'hD5, 8'h00);
    wr(8'hD6, 8'h00);
    wr(8'hDF, 8'h00);
  endtask
  task t_drive;
    global_crossbar_enable = 1'b1;
    wr(8'hB0, 8'h0F);
    wr(8'hA7, 8'h33);
    wr(8'hC7, 8'h3C);
    wr(8'hAE, 8'hFF);
    settle(2);
    chk("p3 oe", port3_pin_oe, 24'hF3);
    chk("p3 high", port3_pin_oe & port3_pin_out, 24'h03);
    chk("p3 pull", port3_pull_en, 24'hCC);
    chk("p4 high", port4_pin_oe & port4_pin_out, 24'h3C);
    global_crossbar_enable = 1'b0;
    settle(2);
    chk("oe off", {port2_pin_oe, port3_pin_oe, port4_pin_oe}, 24'h0);
    wr(8'hB0, 8'hFF);
    wr(8'hA7, 8'h00);
    wr(8'hC7, 8'hFF);
    wr(8'hAE, 8'h00);
  endtask
  task t_read;
    reg [7:0] d;
    ext_en[15:8] = 8'hFF;
    ext_val[15:8] = 8'hA5;
    wr(8'hA7, 8'hFF);
    settle(4);
    rd(8'hB0, 1'b0, d);
    chk("pin read", d, 24'hA5);
    rd(8'hB0, 1'b1, d);
    chk("rmw read", d, 24'hFF);
    wr(8'hDF, 8'h0F);
    wr(8'hF4, 8'hF0);
    settle(4);
    rd(8'hB0, 1'b0, d);
    chk("analog read", d, 24'hA0);
    global_crossbar_enable = 1'b1;
    settle(2);
    chk("analog oe", port3_pin_oe, 24'hF0);
    chk("analog out", port3_pin_out & 8'h0F, 24'h0);
    global_crossbar_enable = 1'b0;
    wr(8'hA7, 8'h00);
    settle(2);
    chk("analog pull", port3_pull_en, 24'hF0);
    wr(8'hF4, 8'hFF);
    wr(8'hDF, 8'h00);
    ext_en[15:8] = 8'h00;
  endtask
  task t_route;
    reg [7:0] d;
    global_crossbar_enable = 1'b1;
    xbar_p2_sel = 8'h0F;
    xbar_p2_data = 8'h05;
    wr(8'hA0, 8'h00);
    wr(8'hA6, 8'hFF);
    settle(2);
    chk("p2 out", port2_pin_out, 24'h05);
    chk("p2 oe", port2_pin_oe, 24'hFF);
    rd(8'hA0, 1'b0, d);
    chk("p2 pin read", d, 24'h05);
    global_crossbar_enable = 1'b0;
    xbar_p2_sel = 8'h00;
    wr(8'hA0, 8'hFF);
    wr(8'hA6, 8'h00);
  endtask
  task t_pud;
    global_pullup_disable = 1'b1;
    settle(2);
    chk("pull off", {port2_pull_en, port3_pull_en, port4_pull_en}, 24'h0);
    global_pullup_disable = 1'b0;
    settle(2);
    chk("pull on", port4_pull_en, 24'hFF);
  endtask
  // Small package pins and map, then a reset in mid-run
  task t_small;
    reg [7:0] d;
    global_crossbar_enable = 1'b1;
    wr(8'hB0, 8'h00);
    wr(8'hA7, 8'hFF);
    settle(2);
    chk("small p3 oe", small_p3_oe, 24'h01);
    chk("small p4 pins", {small_p4_oe, small_p4_pull}, 24'h0);
    rd(8'hB0, 1'b1, d);
    chk("small p3 latch", small_rdata, 24'h00);
    rd(8'hF4, 1'b1, d);
    chk("small p3 mode", small_rdata, 24'h01);
    rd(8'hF5, 1'b1, d);
    chk("small p4 mode", small_rdata, 24'h00);
    chk("large p4 mode", d, 24'hFF);
    global_crossbar_enable = 1'b0;
    wr(8'hD5, 8'h11);
    rst_n = 1'b0;
    settle(2);
    rst_n = 1'b1;
    settle(1);
    chk("reset skip", skip_vec, 24'h0);
    rd(8'hB0, 1'b1, d);
    chk("reset latch", d, 24'hFF);
    rd(8'hA7, 1'b1, d);
    chk("reset drive", d, 24'h00);
  endtask
  initial begin
    #100000;
    errors = errors + 1;
    report_and_stop;
  end
  initial begin
    settle(5);
    rst_n = 1'b1;
    t_regs;
    t_skip;
    t_drive;
    t_read;
    t_route;
    t_pud;
    t_small;
    report_and_stop;
  end
endmodule // tb_ppcb_port_bank
